// *** hdl/ubr_gen.v ***
// Rate generators for two serial channels, timer-1 rate source and LIN sequencing.
// Assumes all inputs except lin_rx_pin come from logic on the same clock.
//
// Behaviour
// R1 - Each channel has own 8-bit reload, prescaler and fractional divider
// R2 - Down-counting rate timer clocked by divider output or prescaler output
// R3 - Rate timer runs only with mode select 0; run bit starts/stops it
// R4 - Underflow reloads timer and emits exactly one pulse to channel; here rate_tick pulses only on every 16th underflow
// R5 - Divider enabled in normal mode stops rate timer, ignores run bit
// R6 - Prescaler divides clock by two to the prescale field
// R7 - Fractional divider scales prescaler output by step over 256
// R8 - Rate equals clock over 16, prescale, reload plus one
// R9 - Software keeps rate at or below clock over 32
// R10 - First channel modes 1 and 3 may use timer 1 overflow
// R11 - Software puts timer 1 in 8-bit auto-reload mode 2
// R12 - Timer-1 rate is 2^double over 32 times 2 times period
// R13 - Normal mode divider counts up from step, shows count in result
// R14 - Normal mode overflow sets overflow flag and raises interrupt
// R15 - Normal mode output runs at prescaler rate over 256 minus step
// R16 - LIN support exists only on the first channel
// R17 - Header is break, synch byte 55 hex, identifier, then response
// R18 - Header transmitted only when operating as master
// R19 - Break held dominant for at least 13 bit times
// R20 - Sync: init, await frame, adopt rate, enter request/response
// R21 - Resynchronisation repeats for every received header
// R22 - Fast LIN rates should use the fractional divider
// R23 - With run bit clear, timer holds count and emits nothing
`timescale 1ns/1ps
`default_nettype none
`include "ubr_map.vh"

module ubr_gen #(
    parameter PRE_W = `UBR_PRE_W
) (
    // Clock and reset
    input  wire             clock,
    input  wire             rst,
    // Per-channel rate configuration, channel 0 in low bits
    input  wire [1:0]       divider_enable,
    input  wire [1:0]       divider_mode_select,
    input  wire [1:0]       rate_run_bit,
    input  wire [15:0]      rate_reload_value,
    input  wire [2*PRE_W-1:0] prescale_field,
    input  wire [15:0]      divider_step_register,
    input  wire [1:0]       divider_overflow_clear,
    // Channel outputs
    output reg  [1:0]       rate_tick,
    output reg  [15:0]      divider_result_register,
    output reg  [1:0]       divider_overflow_flag,
    output reg  [1:0]       divider_irq,
    output reg  [1:0]       divider_output_clock,
    // Timer-1 rate source, first channel only
    input  wire             timer_one_overflow,
    input  wire             double_rate_bit,
    input  wire             use_timer_one,
    input  wire [1:0]       serial_mode,
    output reg              chan0_rate_tick,
    // LIN, first channel only
    input  wire             lin_master,
    input  wire             lin_start,
    input  wire             lin_rate_valid,
    input  wire             lin_rx_pin,
    input  wire             lin_bit_tick,
    output reg              lin_tx_out,
    output reg              lin_tx_oe,
    output reg              lin_measure_en,
    output reg              lin_rate_adopt,
    output reg  [2:0]       lin_state
);

    ////////////////////////////////////////////////////////////////////////
    // Per-channel rate generator

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)                                // R1
        begin : g_ch
            reg  [6:0] pre_cnt_r;
            reg        pre_tick_r;
            reg  [8:0] frac_acc_r;
            reg        mod_tick_r;
            reg  [7:0] nd_cnt_r;
            reg  [7:0] bt_cnt_r;
            reg  [3:0] ovs_r;
            wire [PRE_W-1:0] pf   = prescale_field[g*PRE_W +: PRE_W];
            wire [7:0]       step = divider_step_register[g*8 +: 8];
            wire [7:0]       rel  = rate_reload_value[g*8 +: 8];
            wire [6:0]       pre_top = (7'h01 << pf) - 7'h01;       // R6
            wire frac_mode = divider_enable[g] & ~divider_mode_select[g];
            wire norm_mode = divider_enable[g] &  divider_mode_select[g];
            wire [8:0] acc_sum = {1'b0, frac_acc_r[7:0]} + {1'b0, step};
            // R2: rate timer clock source
            wire bt_clk = divider_enable[g] ? mod_tick_r : pre_tick_r;
            // R3 R5 R23
            wire bt_run = rate_run_bit[g] & ~divider_mode_select[g] & ~norm_mode;
            wire bt_under = bt_run & bt_clk & (bt_cnt_r == `UBR_BYTE_ZERO);

            always @(posedge clock)
            begin
                if (rst)
                begin
                    pre_cnt_r  <= 7'h00;
                    pre_tick_r <= 1'b0;
                    frac_acc_r <= 9'h000;
                    mod_tick_r <= 1'b0;
                    nd_cnt_r   <= `UBR_BYTE_ZERO;
                    bt_cnt_r   <= `UBR_BYTE_ZERO;
                    ovs_r      <= 4'h0;
                    rate_tick[g]               <= 1'b0;
                    divider_result_register[g*8 +: 8] <= `UBR_BYTE_ZERO;
                    divider_overflow_flag[g]   <= 1'b0;
                    divider_irq[g]             <= 1'b0;
                    divider_output_clock[g]    <= 1'b0;
                end
                else
                begin
                    // Prescaler: one tick every 2^field clocks
                    pre_tick_r <= (pre_cnt_r >= pre_top);            // R6
                    pre_cnt_r  <= (pre_cnt_r >= pre_top) ? 7'h00 : pre_cnt_r + 7'h01;
                    mod_tick_r <= 1'b0;
                    divider_irq[g] <= 1'b0;
                    if (frac_mode)
                    begin
                        // Carry out of step accumulation gives step/256 rate
                        if (pre_tick_r)
                        begin
                            frac_acc_r <= acc_sum;                   // R7
                            mod_tick_r <= acc_sum[`UBR_STEP_CARRY];
                        end
                    end
                    else if (norm_mode)
                    begin
                        if (pre_tick_r)
                        begin
                            if (nd_cnt_r == `UBR_BYTE_MAX)
                            begin
                                nd_cnt_r   <= step;                  // R13 R15
                                mod_tick_r <= 1'b1;
                                divider_irq[g] <= 1'b1;              // R14
                            end
                            else
                                nd_cnt_r <= nd_cnt_r + 8'h01;        // R13
                        end
                    end
                    else
                    begin
                        frac_acc_r <= 9'h000;
                        nd_cnt_r   <= step;
                    end
                    divider_result_register[g*8 +: 8] <= nd_cnt_r;  // R13
                    divider_output_clock[g] <= mod_tick_r;
                    // Set beats clear
                    if (norm_mode & pre_tick_r & (nd_cnt_r == `UBR_BYTE_MAX))
                        divider_overflow_flag[g] <= 1'b1;            // R14
                    else if (divider_overflow_clear[g])
                        divider_overflow_flag[g] <= 1'b0;
                    // Rate timer; held while stopped
                    if (bt_run & bt_clk)                             // R23
                        bt_cnt_r <= bt_under ? rel : bt_cnt_r - 8'h01; // R2 R4
                    // Sixteen underflows per bit time
                    rate_tick[g] <= 1'b0;
                    if (bt_under)                                    // R4 R8
                    begin
                        ovs_r <= ovs_r + 4'h1;
                        rate_tick[g] <= (ovs_r == `UBR_OVS_LAST);
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Timer-1 source for the first channel

    reg  [4:0] t1_div_r;
    reg        t1_half_r;
    wire       var_mode = serial_mode[0];                            // R10 modes 1, 3
    wire [4:0] t1_top   = double_rate_bit ? 5'h0F : 5'h1F;          // R12

    always @(posedge clock)
    begin
        if (rst)
        begin
            t1_div_r        <= 5'h00;
            t1_half_r       <= 1'b0;
            chan0_rate_tick <= 1'b0;
        end
        else
        begin
            chan0_rate_tick <= 1'b0;
            if (use_timer_one & var_mode)                           // R10
            begin
                if (timer_one_overflow)
                begin
                    // Divide by 2 then by 32 or 16 by double-rate
                    t1_half_r <= ~t1_half_r;                          // R12
                    if (t1_half_r == `UBR_T1_HALF)
                    begin
                        t1_div_r <= (t1_div_r >= t1_top) ? 5'h00 : t1_div_r + 5'h01;
                        chan0_rate_tick <= (t1_div_r >= t1_top);
                    end
                end
            end
            else
                chan0_rate_tick <= g_ch[0].bt_under & (g_ch[0].ovs_r == `UBR_OVS_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // LIN header and rate synchronisation, first channel only (R16)

    reg        rx_s1_r;
    reg        rx_s2_r;
    reg        rx_s3_r;
    reg  [4:0] brk_cnt_r;
    reg  [2:0] lin_nxt;

    always @(posedge clock)
    begin
        if (rst)
        begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
        end
        else
        begin
            rx_s1_r <= lin_rx_pin;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
        end
    end

    wire rx_fall = rx_s3_r & ~rx_s2_r;

    always @*
    begin
        lin_nxt = lin_state;
        case (lin_state)
            `UBR_LIN_IDLE:  if (lin_start) lin_nxt = `UBR_LIN_INIT;
            `UBR_LIN_INIT:  lin_nxt = `UBR_LIN_WAIT;                 // R20
            `UBR_LIN_WAIT:
            begin
                if (lin_master & (brk_cnt_r == `UBR_BREAK_BITS))
                    lin_nxt = `UBR_LIN_FRAME;                         // R18 R19
                else if (~lin_master & rx_fall)
                    lin_nxt = `UBR_LIN_SYNC;                          // R20
            end
            `UBR_LIN_SYNC:  if (lin_rate_valid) lin_nxt = `UBR_LIN_FRAME;
            `UBR_LIN_FRAME: lin_nxt = `UBR_LIN_INIT;                  // R21
            default:        lin_nxt = `UBR_LIN_IDLE;
        endcase
        if (~lin_start)
            lin_nxt = `UBR_LIN_IDLE;
    end

    always @(posedge clock)
    begin
        if (rst)
        begin
            lin_state      <= `UBR_LIN_IDLE;
            brk_cnt_r      <= 5'h00;
            lin_tx_out     <= 1'b1;
            lin_tx_oe      <= 1'b0;
            lin_measure_en <= 1'b0;
            lin_rate_adopt <= 1'b0;
        end
        else
        begin
            lin_state      <= lin_nxt;
            lin_measure_en <= (lin_nxt == `UBR_LIN_SYNC) | (lin_nxt == `UBR_LIN_WAIT);
            lin_rate_adopt <= (lin_state == `UBR_LIN_SYNC) & lin_rate_valid; // R20
            // Break is dominant low; synch byte 55h and ID go through the UART
            if ((lin_state == `UBR_LIN_WAIT) & lin_master)           // R18
            begin
                lin_tx_oe  <= 1'b1;
                lin_tx_out <= 1'b0;                                   // R17 R19
                // Count only once the pin is low, so no bit time is lost at the start
                if (lin_bit_tick & lin_tx_oe & (brk_cnt_r != `UBR_BREAK_BITS))
                    brk_cnt_r <= brk_cnt_r + 5'h01;
            end
            else
            begin
                lin_tx_oe  <= 1'b0;
                lin_tx_out <= 1'b1;
                brk_cnt_r  <= 5'h00;
            end
        end
    end

endmodule // ubr_gen
`default_nettype wire

// *** hdl/ubr_map.vh ***
// Constants for the two-channel rate generator.
// Assumes inclusion by hdl/ubr_gen.v only.
`ifndef UBR_MAP_VH
`define UBR_MAP_VH
`define UBR_PRE_W        3
`define UBR_BYTE_MAX     8'hFF
`define UBR_BYTE_ZERO    8'h00
`define UBR_ONE9         9'h001
`define UBR_STEP_CARRY   8
`define UBR_OVS_LAST     4'hF
`define UBR_T1_HALF      1'b1
`define UBR_SYNCH_BYTE   8'h55
`define UBR_BREAK_BITS   5'h0D
`define UBR_LIN_IDLE     3'h0
`define UBR_LIN_INIT     3'h1
`define UBR_LIN_WAIT     3'h2
`define UBR_LIN_SYNC     3'h3
`define UBR_LIN_FRAME    3'h4
`endif

// *** tb/ubr_gen_assertions.sv ***
// Checker for ubr_gen, channel 0 and LIN pin.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ubr_gen_assertions (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // Controls
    input wire logic [1:0]  rate_run_bit,
    input wire logic [1:0]  divider_mode_select,
    input wire logic [15:0] divider_step_register,
    input wire logic [1:0]  divider_overflow_clear,
    // Results
    input wire logic [1:0]  rate_tick,
    input wire logic [1:0]  divider_overflow_flag,
    input wire logic [1:0]  divider_irq,
    // LIN
    input wire logic        lin_master,
    input wire logic        lin_bit_tick,
    input wire logic        lin_tx_out,
    input wire logic        lin_tx_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic [4:0] brk_r;
    //////////////////////////////
    // Bit times counted while the break is driven
    always @(posedge clock)
        if (rst || !lin_tx_oe)
            brk_r <= 5'h0;
        else if (lin_bit_tick && brk_r != 5'h1F)
            brk_r <= brk_r + 5'h1;
    property p_run_off; !rate_run_bit[0] [*3] |-> !rate_tick[0]; endproperty
    a_run_off: assert property (p_run_off) else $error("tick while stopped");
    property p_mode_off; divider_mode_select[0] [*3] |-> !rate_tick[0]; endproperty
    a_mode_off: assert property (p_mode_off) else $error("tick in normal mode");
    property p_tick_pulse; rate_tick[0] |=> !rate_tick[0]; endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick too long");
    property p_irq_flag; divider_irq[0] |-> ##[0:1] divider_overflow_flag[0]; endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("irq without flag");
    property p_irq_pulse;
        divider_irq[0] && divider_step_register[7:0] != 8'hFF |=> !divider_irq[0];
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
    property p_flag_hold;
        divider_overflow_flag[0] && !divider_overflow_clear[0] |=> divider_overflow_flag[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_oe_low; lin_tx_oe |-> !lin_tx_out; endproperty
    a_oe_low: assert property (p_oe_low) else $error("break not dominant");
    property p_oe_master; $rose(lin_tx_oe) |-> lin_master; endproperty
    a_oe_master: assert property (p_oe_master) else $error("slave drove break");
    property p_break_len; $fell(lin_tx_oe) |-> brk_r >= 5'h0D; endproperty
    a_break_len: assert property (p_break_len) else $error("break too short");
    c_tick: cover property (rate_tick[0]);
    c_irq: cover property (divider_irq[0]);
    c_break: cover property ($fell(lin_tx_oe));
endmodule // ubr_gen_assertions
bind ubr_gen ubr_gen_assertions ubr_gen_assertions_i (
    .clock(clock), .rst(rst), .rate_run_bit(rate_run_bit),
    .divider_mode_select(divider_mode_select), .divider_step_register(divider_step_register),
    .divider_overflow_clear(divider_overflow_clear), .rate_tick(rate_tick),
    .divider_overflow_flag(divider_overflow_flag), .divider_irq(divider_irq),
    .lin_master(lin_master), .lin_bit_tick(lin_bit_tick), .lin_tx_out(lin_tx_out),
    .lin_tx_oe(lin_tx_oe));
`default_nettype wire

// *** tb/ubr_gen_tb.sv ***
// Self-checking bench for ubr_gen with a LIN host on the pin.
// Assumes design, host model and checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
module ubr_gen_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [1:0]  en = 2'h0, ms = 2'h0, run = 2'h0, clr = 2'h0, sm = 2'h0, tk, fl, irq, doc;
    logic [15:0] rl = 16'h0000, st = 16'h0000, res;
    logic [5:0]  pf = 6'h00;
    logic        tov = 1'b0, dbl = 1'b0, ut = 1'b0, lm = 1'b0, ls = 1'b0, lv = 1'b0;
    logic        btk = 1'b0, hs = 1'b0, c0t, ltx, loe, lme, lad, rx;
    logic [2:0]  lst;
    int          cc = 0, w, p, r, n0, n1, ni, nd, nc, bad_count = 0, cmp_count = 0;
    ubr_gen ubr_gen_i (
        .clock(clock), .rst(rst), .divider_enable(en), .divider_mode_select(ms),
        .rate_run_bit(run), .rate_reload_value(rl), .prescale_field(pf),
        .divider_step_register(st), .divider_overflow_clear(clr), .rate_tick(tk),
        .divider_result_register(res), .divider_overflow_flag(fl), .divider_irq(irq),
        .divider_output_clock(doc), .timer_one_overflow(tov), .double_rate_bit(dbl),
        .use_timer_one(ut), .serial_mode(sm), .chan0_rate_tick(c0t), .lin_master(lm),
        .lin_start(ls), .lin_rate_valid(lv), .lin_rx_pin(rx), .lin_bit_tick(btk),
        .lin_tx_out(ltx), .lin_tx_oe(loe), .lin_measure_en(lme), .lin_rate_adopt(lad),
        .lin_state(lst));
    ubr_lin_host ubr_lin_host_i (.clock(clock), .send(hs), .dev_oe(loe), .dev_tx(ltx), .rx(rx));
    initial forever #2 clock = ~clock;
    //////////////////////////////
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Settle long enough for the slowest period, then count one window
    task automatic win;
        cyc(512);
        {n0, n1, ni, nd, nc} = 0;
        cyc(2048);
    endtask
    // Event counters, overflow and bit-time strobes, and the hang guard
    always @(posedge clock)
    begin
        n0 += tk[0];
        n1 += tk[1];
        ni += irq[0];
        nd += doc[0];
        nc += c0t;
        #1;
        cc++;
        tov = cc[0];
        btk = cc[1:0] == 2'h0;
        if (cc == 60000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    //////////////////////////////
    initial
    begin
        cyc(8);
        rst = 1'b0;
        run = 2'h3;
        for (int i = 0; i < 4; i++)
        begin
            p = i % 3;
            r = (i == 3) ? 3 : 1;
            pf = {3'(p), 3'(p)};
            rl = {8'(2 * r + 1), 8'(r)};
            win();
            chk("tick0", 16'(n0), 16'(2048 / ((16 << p) * (r + 1))));
            chk("tick1", 16'(n1), 16'(2048 / ((16 << p) * (2 * r + 2))));
        end
        $display("rate test done");
        {en, st, pf, rl} = {2'h1, 16'h0080, 6'h00, 16'h0301};
        win();
        chk("frac", 16'(n0), 16'h0020);
        st = 16'h00F0;
        for (int i = 0; i < 3; i++)
        begin
            run = i ? 2'h3 : 2'h0;
            ms = i ? 2'h1 : 2'h0;
            en = (i == 2) ? 2'h1 : 2'h0;
            win();
            chk("stopped", 16'(n0), 16'h0000);
        end
        chk("ovf_irq", 16'(ni), 16'h0080);
        chk("div_out", 16'(nd), 16'h0080);
        chk("flag", fl[0], 16'h0001);
        chk("result", res[7:0] >= 8'hF0, 16'h0001);
        {ms, en} = 4'h0;
        cyc(2);
        clr = 2'h1;
        cyc(1);
        clr = 2'h0;
        cyc(2);
        chk("flag_clr", fl[0], 16'h0000);
        $display("divider test done");
        ut = 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            sm = i ? 2'h3 : 2'h1;
            dbl = i[0];
            win();
            chk("t1_tick", 16'(nc), 16'(16 << i));
        end
        ut = 1'b0;
        $display("timer one test done");
        // LIN start is a level; dropping it returns the sequencer to idle
        lm = 1'b1;
        ls = 1'b1;
        for (w = 0; loe !== 1'b1 && w < 100; w++) cyc(1);
        for (w = 0; loe === 1'b1 && w < 1000; w++) cyc(1);
        ls = 1'b0;
        chk("break_len", w >= 49 && w < 1000, 16'h0001);
        chk("idle_hi", ltx, 16'h0001);
        lm = 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            ls = 1'b1;
            cyc(4);
            hs = 1'b1;
            cyc(1);
            hs = 1'b0;
            for (w = 0; lst !== 3'h3 && w < 3000; w++) cyc(1);
            chk("sync", lst, 16'h0003);
            chk("measure", lme, 16'h0001);
            cyc(8);
            lv = 1'b1;
            cyc(1);
            lv = 1'b0;
            for (w = 0; lad !== 1'b1 && w < 50; w++) cyc(1);
            chk("adopt", lad, 16'h0001);
            for (w = 0; lst !== 3'h1 && w < 50; w++) cyc(1);
            chk("reinit", lst, 16'h0001);
            ls = 1'b0;
            // Let the whole host frame pass before the next header
            cyc(2000);
            chk("measure_off", lme, 16'h0000);
        end
        $display("lin test done");
        print_verdict();
    end
endmodule // ubr_gen_tb
`default_nettype wire

// *** tb/ubr_lin_host.sv ***
// LIN host model: break and synch byte on request, wired-AND bus.
// Assumes a bit time of BT clock cycles and a pull-up on the bus.
`timescale 1ns/1ps
`default_nettype none
module ubr_lin_host #(
    parameter int BT = 64
) (
    // Clock
    input  wire logic clock,
    // Request
    input  wire logic send,
    // Device side of the pin
    input  wire logic dev_oe,
    input  wire logic dev_tx,
    output var logic  rx
);
    logic [23:0] sh_r = 24'hFF_FFFF;
    int          t_r  = 0;
    //////////////////////////////
    // Ones shift in behind the frame, so the bus goes idle by itself
    always @(posedge clock)
        if (send)
        begin
            sh_r <= {1'b1, 8'h55, 1'b0, 1'b1, 13'h0000};
            t_r  <= BT;
        end
        else if (t_r == 1)
        begin
            sh_r <= {1'b1, sh_r[23:1]};
            t_r  <= BT;
        end
        else if (t_r > 1)
            t_r <= t_r - 1;
    // Either side pulling low wins
    assign rx = sh_r[0] & ~(dev_oe & ~dev_tx);
endmodule // ubr_lin_host
`default_nettype wire
